/* common/albod_defines.svh */
`ifndef ALBOD_DEFINES_SVH
`define ALBOD_DEFINES_SVH

// ----------------------------------------------------------------------
// Opcode masks and values
// ----------------------------------------------------------------------
`define ALBOD_M_FULL      8'hFF
`define ALBOD_M_W         8'hFE
`define ALBOD_M_DW        8'hFC
`define ALBOD_OP_BRW_ACC  8'h1C
`define ALBOD_OP_SUB_RM   8'h28
`define ALBOD_OP_SUB_ACC  8'h2C
`define ALBOD_OP_AND_ACC  8'h24
`define ALBOD_OP_TEST_RM  8'h84
`define ALBOD_OP_TEST_ACC 8'hA8
`define ALBOD_OP_IMM_GRP  8'h80
`define ALBOD_OP_UNA_GRP  8'hF6
`define ALBOD_OP_SHF_GRP  8'hD0
`define ALBOD_OP_UADD     8'h37
`define ALBOD_OP_PADD     8'h27
`define ALBOD_OP_USUB     8'h3F
`define ALBOD_OP_PSUB     8'h2F
`define ALBOD_OP_BMUL     8'hD4
`define ALBOD_OP_BDIV     8'hD5
`define ALBOD_OP_BCD_BASE 8'h0A
`define ALBOD_OP_B2W      8'h98
`define ALBOD_OP_W2D      8'h99
`define ALBOD_OP_BCOPY    8'hA4
`define ALBOD_OP_BCMP     8'hA6
`define ALBOD_OP_BSCAN    8'hAE
`define ALBOD_OP_BLOAD    8'hAC
`define ALBOD_OP_BSTORE   8'hAA
`define ALBOD_OP_ITR      8'hF2
`define ALBOD_OP_BR_NEAR  8'hE9
`define ALBOD_OP_BR_SHORT 8'hEB
`define ALBOD_OP_BR_FAR   8'hEA
`define ALBOD_OP_EXIT     8'hC3
`define ALBOD_OP_EXIT_IMM 8'hC2

// ----------------------------------------------------------------------
// Extension field codes
// ----------------------------------------------------------------------
`define ALBOD_X_0 3'h0
`define ALBOD_X_1 3'h1
`define ALBOD_X_2 3'h2
`define ALBOD_X_3 3'h3
`define ALBOD_X_4 3'h4
`define ALBOD_X_5 3'h5
`define ALBOD_X_6 3'h6
`define ALBOD_X_7 3'h7

// ----------------------------------------------------------------------
// Field positions, addressing forms, byte counts
// ----------------------------------------------------------------------
`define ALBOD_W_BIT   0
`define ALBOD_D_BIT   1
`define ALBOD_S_BIT   1
`define ALBOD_V_BIT   1
`define ALBOD_Z_BIT   0
`define ALBOD_MOD_HI  7
`define ALBOD_MOD_LO  6
`define ALBOD_EXT_HI  5
`define ALBOD_EXT_LO  3
`define ALBOD_RM_HI   2
`define ALBOD_RM_LO   0
`define ALBOD_MOD_MEM 2'h0
`define ALBOD_MOD_D8  2'h1
`define ALBOD_MOD_D16 2'h2
`define ALBOD_RM_DIR  3'h6
`define ALBOD_LEN_0   3'h0
`define ALBOD_LEN_1   3'h1
`define ALBOD_LEN_2   3'h2
`define ALBOD_LEN_4   3'h4

`endif

/* common/albod_pkg.sv */
package albod_pkg;

  typedef enum logic [5:0] {
    ALBOD_OUTSIDE, ALBOD_BORROW_DIFFERENCE, ALBOD_DIFFERENCE,
    ALBOD_FLAGS_AND, ALBOD_AND,
    ALBOD_BCD_UNPACKED_ADD_ADJUST, ALBOD_BCD_PACKED_ADD_ADJUST,
    ALBOD_BCD_UNPACKED_MINUS_ADJUST, ALBOD_BCD_PACKED_MINUS_ADJUST,
    ALBOD_INVERT, ALBOD_SIGN_CHANGE,
    ALBOD_UNSIGNED_PRODUCT, ALBOD_SIGNED_PRODUCT,
    ALBOD_UNSIGNED_QUOTIENT, ALBOD_SIGNED_QUOTIENT,
    ALBOD_BCD_MULTIPLY_ADJUST, ALBOD_BCD_DIVIDE_ADJUST,
    ALBOD_BYTE_TO_WORD_EXTEND, ALBOD_WORD_TO_DOUBLEWORD_EXTEND,
    ALBOD_LEFT_ROTATE, ALBOD_RIGHT_ROTATE,
    ALBOD_LEFT_ROTATE_VIA_CARRY, ALBOD_RIGHT_ROTATE_VIA_CARRY,
    ALBOD_LEFT_SHIFT, ALBOD_LOGICAL_RIGHT_SHIFT,
    ALBOD_ARITHMETIC_RIGHT_SHIFT,
    ALBOD_BLOCK_COPY, ALBOD_BLOCK_COMPARE, ALBOD_BLOCK_SCAN,
    ALBOD_BLOCK_LOAD, ALBOD_BLOCK_STORE, ALBOD_ITERATION_PREFIX,
    ALBOD_BRANCH_NEAR, ALBOD_BRANCH_SHORT, ALBOD_BRANCH_FAR,
    ALBOD_PROCEDURE_EXIT, ALBOD_PROCEDURE_EXIT_ADJUST,
    ALBOD_INVALID
  } albod_op_type;

  typedef enum logic [0:0] {
    ALBOD_ITR_IDLE  = 1'b0,
    ALBOD_ITR_ARMED = 1'b1
  } albod_itr_state_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] byte0;
    logic [7:0] byte1;
  } albod_window_type;

  typedef struct packed {
    logic         valid;
    albod_op_type op;
    logic         word;
    logic         to_reg;
    logic         count_from_reg;
    logic         carry_chain;
    logic         flags_only;
    logic         sp_adjust;
    logic         itr_active;
    logic         itr_zf;
    logic         invalid;
    logic [2:0]   length;
  } albod_decode_type;

endpackage

/* rtl/albod_decoder.sv */
`timescale 1ns/1ps
`include "albod_defines.svh"

module albod_decoder
  import albod_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire albod_window_type window,
  output albod_decode_type      decode
);

  // --------------------------------------------------------------------
  // Field extraction
  // --------------------------------------------------------------------
  logic [7:0] op_byte;
  logic [7:0] mod_byte;
  logic [2:0] ext;
  logic [1:0] mod_field;
  logic [2:0] rm_field;
  logic       w_bit;
  logic       sw_one_byte;
  logic [2:0] disp_len;
  logic [2:0] imm_w_len;
  logic [2:0] imm_sw_len;

  assign op_byte   = window.byte0;
  assign mod_byte  = window.byte1;
  assign ext       = mod_byte[`ALBOD_EXT_HI:`ALBOD_EXT_LO];
  assign mod_field = mod_byte[`ALBOD_MOD_HI:`ALBOD_MOD_LO];
  assign rm_field  = mod_byte[`ALBOD_RM_HI:`ALBOD_RM_LO];
  assign w_bit     = op_byte[`ALBOD_W_BIT];

  // Byte immediate unless s:w is 01
  assign sw_one_byte = op_byte[`ALBOD_S_BIT] | ~w_bit;

  // Trailing displacement bytes implied by the addressing form
  always_comb
  begin
    disp_len = `ALBOD_LEN_0;
    if (mod_field == `ALBOD_MOD_D8)
    begin
      disp_len = `ALBOD_LEN_1;
    end
    else if (mod_field == `ALBOD_MOD_D16)
    begin
      disp_len = `ALBOD_LEN_2;
    end
    else if (mod_field == `ALBOD_MOD_MEM && rm_field == `ALBOD_RM_DIR)
    begin
      disp_len = `ALBOD_LEN_2;
    end
  end

  assign imm_w_len  = w_bit ? `ALBOD_LEN_2 : `ALBOD_LEN_1;
  assign imm_sw_len = sw_one_byte ? `ALBOD_LEN_1 : `ALBOD_LEN_2;

  function automatic logic hit(input logic [7:0] b,
                               input logic [7:0] mask,
                               input logic [7:0] value);
    hit = (b & mask) == value;
  endfunction

  // --------------------------------------------------------------------
  // Opcode decode
  // --------------------------------------------------------------------
  albod_decode_type    next_decode;
  albod_itr_state_type itr_state;
  albod_itr_state_type next_itr_state;
  logic                itr_zf;
  logic                next_itr_zf;
  logic [2:0]          rm_len;
  logic [2:0]          acc_len;

  assign rm_len  = `ALBOD_LEN_2 + disp_len;
  assign acc_len = `ALBOD_LEN_1 + imm_w_len;

  always_comb
  begin
    next_decode    = '0;
    next_itr_state = itr_state;
    next_itr_zf    = itr_zf;
    if (window.valid)
    begin
      next_decode.valid  = 1'b1;
      next_decode.op     = ALBOD_OUTSIDE;
      next_decode.word   = w_bit;
      next_decode.length = `ALBOD_LEN_1;
      if (hit(op_byte, `ALBOD_M_W, `ALBOD_OP_BRW_ACC))
      begin
        next_decode.op     = ALBOD_BORROW_DIFFERENCE;
        next_decode.length = acc_len;
      end
      else if (hit(op_byte, `ALBOD_M_DW, `ALBOD_OP_SUB_RM))
      begin
        next_decode.op     = ALBOD_DIFFERENCE;
        next_decode.to_reg = op_byte[`ALBOD_D_BIT];
        next_decode.length = rm_len;
      end
      else if (hit(op_byte, `ALBOD_M_W, `ALBOD_OP_SUB_ACC))
      begin
        next_decode.op     = ALBOD_DIFFERENCE;
        next_decode.length = acc_len;
      end
      else if (hit(op_byte, `ALBOD_M_W, `ALBOD_OP_TEST_RM))
      begin
        next_decode.op         = ALBOD_FLAGS_AND;
        next_decode.flags_only = 1'b1;
        next_decode.length     = rm_len;
      end
      else if (hit(op_byte, `ALBOD_M_W, `ALBOD_OP_TEST_ACC))
      begin
        next_decode.op         = ALBOD_FLAGS_AND;
        next_decode.flags_only = 1'b1;
        next_decode.length     = acc_len;
      end
      else if (hit(op_byte, `ALBOD_M_W, `ALBOD_OP_AND_ACC))
      begin
        next_decode.op     = ALBOD_AND;
        next_decode.length = acc_len;
      end
      else if (hit(op_byte, `ALBOD_M_DW, `ALBOD_OP_IMM_GRP))
      begin
        next_decode.length = rm_len + imm_sw_len;
        case (ext)
          `ALBOD_X_3: next_decode.op = ALBOD_BORROW_DIFFERENCE;
          `ALBOD_X_4:
          begin
            next_decode.op     = ALBOD_AND;
            next_decode.length = rm_len + imm_w_len;
          end
          `ALBOD_X_5: next_decode.op = ALBOD_DIFFERENCE;
          default:    next_decode.op = ALBOD_OUTSIDE;
        endcase
      end
      else if (hit(op_byte, `ALBOD_M_W, `ALBOD_OP_UNA_GRP))
      begin
        next_decode.length = rm_len;
        case (ext)
          `ALBOD_X_0:
          begin
            next_decode.op         = ALBOD_FLAGS_AND;
            next_decode.flags_only = 1'b1;
            next_decode.length     = rm_len + imm_w_len;
          end
          `ALBOD_X_2: next_decode.op = ALBOD_INVERT;
          `ALBOD_X_3: next_decode.op = ALBOD_SIGN_CHANGE;
          `ALBOD_X_4: next_decode.op = ALBOD_UNSIGNED_PRODUCT;
          `ALBOD_X_5: next_decode.op = ALBOD_SIGNED_PRODUCT;
          `ALBOD_X_6: next_decode.op = ALBOD_UNSIGNED_QUOTIENT;
          `ALBOD_X_7: next_decode.op = ALBOD_SIGNED_QUOTIENT;
          default:
          begin
            next_decode.op      = ALBOD_INVALID;
            next_decode.invalid = 1'b1;
          end
        endcase
      end
      else if (hit(op_byte, `ALBOD_M_DW, `ALBOD_OP_SHF_GRP))
      begin
        next_decode.length         = rm_len;
        next_decode.count_from_reg = op_byte[`ALBOD_V_BIT];
        case (ext)
          `ALBOD_X_0: next_decode.op = ALBOD_LEFT_ROTATE;
          `ALBOD_X_1: next_decode.op = ALBOD_RIGHT_ROTATE;
          `ALBOD_X_2:
          begin
            next_decode.op          = ALBOD_LEFT_ROTATE_VIA_CARRY;
            next_decode.carry_chain = 1'b1;
          end
          `ALBOD_X_3:
          begin
            next_decode.op          = ALBOD_RIGHT_ROTATE_VIA_CARRY;
            next_decode.carry_chain = 1'b1;
          end
          `ALBOD_X_4: next_decode.op = ALBOD_LEFT_SHIFT;
          `ALBOD_X_5: next_decode.op = ALBOD_LOGICAL_RIGHT_SHIFT;
          `ALBOD_X_7: next_decode.op = ALBOD_ARITHMETIC_RIGHT_SHIFT;
          default:
          begin
            next_decode.op      = ALBOD_INVALID;
            next_decode.invalid = 1'b1;
          end
        endcase
      end
      else if (hit(op_byte, `ALBOD_M_FULL, `ALBOD_OP_BMUL) ||
               hit(op_byte, `ALBOD_M_FULL, `ALBOD_OP_BDIV))
      begin
        next_decode.length = `ALBOD_LEN_2;
        if (mod_byte != `ALBOD_OP_BCD_BASE)
        begin
          next_decode.op      = ALBOD_INVALID;
          next_decode.invalid = 1'b1;
        end
        else if (op_byte == `ALBOD_OP_BMUL)
        begin
          next_decode.op = ALBOD_BCD_MULTIPLY_ADJUST;
        end
        else
        begin
          next_decode.op = ALBOD_BCD_DIVIDE_ADJUST;
        end
      end
      else if (hit(op_byte, `ALBOD_M_W, `ALBOD_OP_ITR))
      begin
        next_decode.op = ALBOD_ITERATION_PREFIX;
        next_itr_state = ALBOD_ITR_ARMED;
        next_itr_zf    = op_byte[`ALBOD_Z_BIT];
      end
      else
      begin
        case (op_byte)
          `ALBOD_OP_UADD:
            next_decode.op = ALBOD_BCD_UNPACKED_ADD_ADJUST;
          `ALBOD_OP_PADD:
            next_decode.op = ALBOD_BCD_PACKED_ADD_ADJUST;
          `ALBOD_OP_USUB:
            next_decode.op = ALBOD_BCD_UNPACKED_MINUS_ADJUST;
          `ALBOD_OP_PSUB:
            next_decode.op = ALBOD_BCD_PACKED_MINUS_ADJUST;
          `ALBOD_OP_B2W:
            next_decode.op = ALBOD_BYTE_TO_WORD_EXTEND;
          `ALBOD_OP_W2D:
            next_decode.op = ALBOD_WORD_TO_DOUBLEWORD_EXTEND;
          `ALBOD_OP_BR_NEAR:
          begin
            next_decode.op     = ALBOD_BRANCH_NEAR;
            next_decode.length = `ALBOD_LEN_1 + `ALBOD_LEN_2;
          end
          `ALBOD_OP_BR_SHORT:
          begin
            next_decode.op     = ALBOD_BRANCH_SHORT;
            next_decode.length = `ALBOD_LEN_2;
          end
          `ALBOD_OP_BR_FAR:
          begin
            next_decode.op     = ALBOD_BRANCH_FAR;
            next_decode.length = `ALBOD_LEN_1 + `ALBOD_LEN_4;
          end
          `ALBOD_OP_EXIT:
            next_decode.op = ALBOD_PROCEDURE_EXIT;
          `ALBOD_OP_EXIT_IMM:
          begin
            next_decode.op        = ALBOD_PROCEDURE_EXIT_ADJUST;
            next_decode.sp_adjust = 1'b1;
            next_decode.length    = `ALBOD_LEN_1 + `ALBOD_LEN_2;
          end
          default:
          begin
            // Single-byte block operations, size bit masked off
            case (op_byte & `ALBOD_M_W)
              `ALBOD_OP_BCOPY:  next_decode.op = ALBOD_BLOCK_COPY;
              `ALBOD_OP_BCMP:   next_decode.op = ALBOD_BLOCK_COMPARE;
              `ALBOD_OP_BSCAN:  next_decode.op = ALBOD_BLOCK_SCAN;
              `ALBOD_OP_BLOAD:  next_decode.op = ALBOD_BLOCK_LOAD;
              `ALBOD_OP_BSTORE: next_decode.op = ALBOD_BLOCK_STORE;
              default:          next_decode.op = ALBOD_OUTSIDE;
            endcase
          end
        endcase
      end

      // A pending prefix is attached to the next instruction and spent
      if (next_decode.op != ALBOD_ITERATION_PREFIX)
      begin
        next_decode.itr_active = itr_state == ALBOD_ITR_ARMED;
        next_decode.itr_zf     = itr_zf;
        next_itr_state         = ALBOD_ITR_IDLE;
        next_itr_zf            = 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // State and output registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      decode    <= '0;
      itr_state <= ALBOD_ITR_IDLE;
      itr_zf    <= 1'b0;
    end
    else
    begin
      decode    <= next_decode;
      itr_state <= next_itr_state;
      itr_zf    <= next_itr_zf;
    end
  end

endmodule // albod_decoder

/* tb/albod_properties.sv */
`timescale 1ns/1ps
module albod_properties
  import albod_pkg::*;
(
  input wire logic             clk_sys,
  input wire logic             reset,
  input wire albod_window_type window,
  input wire albod_decode_type decode
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Decode timing and fields
  // ----------------------------------------------------------------
  chk_valid_latency: assert property (
    window.valid |=> decode.valid) else $error("decode valid missing");
  chk_idle_quiet: assert property (
    !window.valid |=> !decode.valid) else $error("spurious decode valid");
  chk_size_bit: assert property (
    window.valid |=> decode.word == $past(window.byte0[0]))
    else $error("size bit not passed on");
  chk_add_adjust: assert property (
    window.valid && window.byte0 == 8'h37 |=> decode.length == 3'h1
    && decode.op == ALBOD_BCD_UNPACKED_ADD_ADJUST) else $error("add adjust");
  chk_product_adjust: assert property (
    window.valid && window.byte0 == 8'hD4 && window.byte1 == 8'h0A
    |=> decode.length == 3'h2 && !decode.invalid)
    else $error("multiply adjust");
  chk_shift_count: assert property (
    window.valid && window.byte0[7:2] == 6'h34
    |=> decode.count_from_reg == $past(window.byte0[1]))
    else $error("shift count source wrong");
  chk_carry_chain: assert property (
    window.valid && window.byte0[7:2] == 6'h34 && window.byte1[5:4] == 2'h1
    |=> decode.carry_chain) else $error("carry chain missing");
  chk_exit_adjust: assert property (
    window.valid && window.byte0 == 8'hC2
    |=> decode.sp_adjust && decode.length == 3'h3) else $error("exit adjust");
  chk_group_invalid: assert property (
    window.valid && window.byte0[7:1] == 7'h7B && window.byte1[5:3] == 3'h1
    |=> decode.invalid) else $error("unassigned extension not flagged");
  chk_prefix_zero: assert property (
    (window.valid && window.byte0 == 8'hF3) ##1 !window.valid ##1
    (window.valid && window.byte0[7:1] == 7'h53)
    |=> decode.itr_active && decode.itr_zf) else $error("repeat zero bit");

  cover property (window.valid && window.byte0 == 8'hF3);
  cover property (decode.invalid);
  cover property (decode.sp_adjust);

endmodule // albod_properties

bind albod_decoder albod_properties chk (
  .clk_sys(clk_sys),
  .reset  (reset),
  .window (window),
  .decode (decode)
);

/* tb/albod_prefetch_model.sv */
`timescale 1ns/1ps
module albod_prefetch_model
  import albod_pkg::*;
(
  input  wire logic       clk_sys,
  output albod_window_type window
);

  initial window = '0;

  // Offers one window for one cycle, then shows inverted stale bytes
  task automatic present(input logic [7:0] b0, input logic [7:0] b1);
    @(posedge clk_sys);
    #1;
    window = '{1'b1, b0, b1};
    @(posedge clk_sys);
    #1;
    window = '{1'b0, ~b0, ~b1};
  endtask

endmodule // albod_prefetch_model

/* tb/tb_alu_branch_opcode_decoder.sv */
`timescale 1ns/1ps
`define CHK(a, b) cmp(64'(a), 64'(b))
module tb_alu_branch_opcode_decoder
  import albod_pkg::*;
;

  logic             clk_sys;
  logic             reset;
  albod_window_type window;
  albod_decode_type decode;
  int               error_cnt;
  int               n_tests;

  albod_decoder uut (.clk_sys(clk_sys), .reset(reset), .window(window),
                     .decode(decode));
  albod_prefetch_model pf (.clk_sys(clk_sys), .window(window));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic dec(input logic [7:0] b0, input logic [7:0] b1,
                     input albod_op_type op, input logic [2:0] len);
    pf.present(b0, b1);
    `CHK(decode.valid, 1'b1);
    `CHK(decode.op, op);
    `CHK(decode.length, len);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_subtract();
    dec(8'h1C, 8'h00, ALBOD_BORROW_DIFFERENCE, 3'h2);
    dec(8'h83, 8'hD8, ALBOD_BORROW_DIFFERENCE, 3'h3);
    dec(8'h81, 8'h9E, ALBOD_BORROW_DIFFERENCE, 3'h6);
    dec(8'h2A, 8'hC0, ALBOD_DIFFERENCE, 3'h2);
    `CHK(decode.to_reg, 1'b1);
    `CHK(decode.word, 1'b0);
    dec(8'h29, 8'h06, ALBOD_DIFFERENCE, 3'h4);
    `CHK(decode.to_reg, 1'b0);
    `CHK(decode.word, 1'b1);
    dec(8'h2D, 8'h00, ALBOD_DIFFERENCE, 3'h3);
    dec(8'h28, 8'h40, ALBOD_DIFFERENCE, 3'h3);
    dec(8'h82, 8'hE8, ALBOD_DIFFERENCE, 3'h3);
    dec(8'h80, 8'hC0, ALBOD_OUTSIDE, 3'h3);
  endtask

  task automatic t_adjust();
    logic [7:0]   code [6] = '{8'h37, 8'h27, 8'h3F, 8'h2F, 8'h98, 8'h99};
    albod_op_type kind [6] = '{ALBOD_BCD_UNPACKED_ADD_ADJUST,
      ALBOD_BCD_PACKED_ADD_ADJUST, ALBOD_BCD_UNPACKED_MINUS_ADJUST,
      ALBOD_BCD_PACKED_MINUS_ADJUST, ALBOD_BYTE_TO_WORD_EXTEND,
      ALBOD_WORD_TO_DOUBLEWORD_EXTEND};
    for (int i = 0; i < 6; i++)
      dec(code[i], 8'h0A, kind[i], 3'h1);
  endtask

  task automatic t_unary();
    albod_op_type kind [8] = '{ALBOD_FLAGS_AND, ALBOD_INVALID, ALBOD_INVERT,
      ALBOD_SIGN_CHANGE, ALBOD_UNSIGNED_PRODUCT, ALBOD_SIGNED_PRODUCT,
      ALBOD_UNSIGNED_QUOTIENT, ALBOD_SIGNED_QUOTIENT};
    for (int i = 0; i < 8; i++)
    begin
      pf.present(8'hF7, 8'hC0 | 8'(i << 3));
      `CHK(decode.length, (i == 0) ? 3'h4 : 3'h2);
      `CHK(decode.invalid, i == 1);
      `CHK(decode.flags_only, i == 0);
      if (i != 1)
        `CHK(decode.op, kind[i]);
    end
    dec(8'hF6, 8'hC0, ALBOD_FLAGS_AND, 3'h3);
  endtask

  task automatic t_shifts();
    albod_op_type kind [8] = '{ALBOD_LEFT_ROTATE, ALBOD_RIGHT_ROTATE,
      ALBOD_LEFT_ROTATE_VIA_CARRY, ALBOD_RIGHT_ROTATE_VIA_CARRY,
      ALBOD_LEFT_SHIFT, ALBOD_LOGICAL_RIGHT_SHIFT, ALBOD_INVALID,
      ALBOD_ARITHMETIC_RIGHT_SHIFT};
    for (int i = 0; i < 8; i++)
    begin
      pf.present(8'hD0 + 8'(i % 4), 8'hC0 | 8'(i << 3));
      `CHK(decode.length, 3'h2);
      `CHK(decode.count_from_reg, (i % 4) >= 2);
      `CHK(decode.carry_chain, i == 2 || i == 3);
      `CHK(decode.invalid, i == 6);
      if (i != 6)
        `CHK(decode.op, kind[i]);
    end
  endtask

  task automatic t_and_test();
    dec(8'h24, 8'h00, ALBOD_AND, 3'h2);
    dec(8'h25, 8'h00, ALBOD_AND, 3'h3);
    dec(8'h80, 8'hE0, ALBOD_AND, 3'h3);
    dec(8'h81, 8'hE0, ALBOD_AND, 3'h4);
    dec(8'h83, 8'hE0, ALBOD_AND, 3'h4);
    dec(8'h84, 8'hC0, ALBOD_FLAGS_AND, 3'h2);
    `CHK(decode.flags_only, 1'b1);
    dec(8'hA9, 8'h00, ALBOD_FLAGS_AND, 3'h3);
    `CHK(decode.flags_only, 1'b1);
  endtask

  task automatic t_strings();
    logic [7:0]   code [5] = '{8'hA4, 8'hA7, 8'hAE, 8'hAD, 8'hAA};
    albod_op_type kind [5] = '{ALBOD_BLOCK_COPY, ALBOD_BLOCK_COMPARE,
      ALBOD_BLOCK_SCAN, ALBOD_BLOCK_LOAD, ALBOD_BLOCK_STORE};
    for (int i = 0; i < 5; i++)
      dec(code[i], 8'h0A, kind[i], 3'h1);
    dec(8'hF3, 8'h00, ALBOD_ITERATION_PREFIX, 3'h1);
    dec(8'hA6, 8'h00, ALBOD_BLOCK_COMPARE, 3'h1);
    `CHK({decode.itr_active, decode.itr_zf}, 2'h3);
    dec(8'hF2, 8'h00, ALBOD_ITERATION_PREFIX, 3'h1);
    repeat (3) @(posedge clk_sys);
    dec(8'hAF, 8'h00, ALBOD_BLOCK_SCAN, 3'h1);
    `CHK({decode.itr_active, decode.itr_zf}, 2'h2);
    dec(8'hA5, 8'h00, ALBOD_BLOCK_COPY, 3'h1);
    `CHK(decode.itr_active, 1'b0);
  endtask

  // Reset in mid-run clears the output and a pending prefix
  task automatic t_reset();
    dec(8'hF3, 8'h00, ALBOD_ITERATION_PREFIX, 3'h1);
    reset = 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK(decode, '0);
    reset = 1'b0;
    dec(8'hA6, 8'h00, ALBOD_BLOCK_COMPARE, 3'h1);
    `CHK(decode.itr_active, 1'b0);
  endtask

  task automatic t_control();
    dec(8'hE9, 8'h00, ALBOD_BRANCH_NEAR, 3'h3);
    dec(8'hEB, 8'h00, ALBOD_BRANCH_SHORT, 3'h2);
    dec(8'hEA, 8'h00, ALBOD_BRANCH_FAR, 3'h5);
    dec(8'hC3, 8'h00, ALBOD_PROCEDURE_EXIT, 3'h1);
    `CHK(decode.sp_adjust, 1'b0);
    dec(8'hC2, 8'h00, ALBOD_PROCEDURE_EXIT_ADJUST, 3'h3);
    `CHK(decode.sp_adjust, 1'b1);
    dec(8'hD4, 8'h0A, ALBOD_BCD_MULTIPLY_ADJUST, 3'h2);
    `CHK(decode.invalid, 1'b0);
    dec(8'hD5, 8'h0A, ALBOD_BCD_DIVIDE_ADJUST, 3'h2);
    pf.present(8'hD5, 8'h0B);
    `CHK(decode.invalid, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    error_cnt = 0;
    n_tests   = 0;
    reset     = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 reset = 1'b0;
    `CHK(decode, '0);
    t_subtract();
    t_adjust();
    t_unary();
    t_shifts();
    t_and_test();
    t_strings();
    t_control();
    t_reset();
    stop_test();
  end

  initial
  begin
    #100000;
    error_cnt++;
    stop_test();
  end

endmodule // tb_alu_branch_opcode_decoder
